// ---- core/rimc_cfg.svh ----
// rimc_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the design modules
`ifndef RIMC_CFG_SVH
`define RIMC_CFG_SVH

// register addresses on the serial interface, 6-bit space
`define RIMC_ADDR_W          6
`define RIMC_OFS_IDENT       6'h00
`define RIMC_OFS_CONTROL     6'h03
`define RIMC_OFS_LOCK_CNT    6'h38

// control register field positions
`define RIMC_CTL_RX_BIT      7
`define RIMC_CTL_TX_BIT      6
`define RIMC_CTL_HALF_BIT    5
`define RIMC_CTL_BYPASS_BIT  4
`define RIMC_CTL_SRC_BIT     3
`define RIMC_CTL_AMP_BIT     2

// identification register field positions
`define RIMC_ID_REV_MSB      7
`define RIMC_ID_REV_LSB      4
`define RIMC_ID_PROD_MSB     3
`define RIMC_ID_PROD_LSB     0

// reset values
`define RIMC_CONTROL_RST     8'h00
`define RIMC_LOCK_CNT_RST    8'h64

// command byte: top bit set means write
`define RIMC_CMD_WR_BIT      7

// timing: one lock count unit in ns, clock period in ns
`define RIMC_LOCK_UNIT_NS    2000
`define RIMC_CLK_PERIOD_NS   4
`define RIMC_LOCK_UNIT_CYC   (`RIMC_LOCK_UNIT_NS / `RIMC_CLK_PERIOD_NS)

`endif

// ---- core/rimc_pkg.sv ----
// rimc_pkg: types shared by the mode control block and its settle sequencer
// assumes: rimc_cfg.svh is on the include path
package rimc_pkg;
  `include "rimc_cfg.svh"

  // decoded control register fields
  typedef struct packed {
    logic rx_en;        // receive mode
    logic tx_en;        // transmit mode
    logic code_half;    // upper half of code when set
    logic lock_bypass;  // ignore synthesizer lock
    logic amp_src;      // firmware owns amplifier when set
    logic amp_en;       // firmware amplifier enable
  } rimc_ctrl_t;

  // serial slave phases, one-hot
  typedef enum logic [3:0] {
    RIMC_SPI_IDLE = 4'b0001,
    RIMC_SPI_ADDR = 4'b0010,
    RIMC_SPI_DATA = 4'b0100,
    RIMC_SPI_DONE = 4'b1000
  } rimc_spi_st_t;

  // settle sequencer states, one-hot
  typedef enum logic [2:0] {
    RIMC_SET_IDLE  = 3'b001,
    RIMC_SET_LOCK  = 3'b010,
    RIMC_SET_COUNT = 3'b100
  } rimc_set_st_t;
endpackage

// ---- core/rimc_settle.sv ----
// rimc_settle: synthesizer settle wait, optional lock wait then a 2 us unit count
// assumes: lock input already synchronised to mclk_i; start is a one-cycle pulse
`timescale 1ns/100ps
`include "rimc_cfg.svh"
module rimc_settle #(
  parameter int UNIT_CYC = `RIMC_LOCK_UNIT_CYC  // cycles per count unit
) (
  input  wire logic       mclk_i,      // device clock
  input  wire logic       rst_b_i,     // sync reset, active low
  input  wire logic       start_i,     // begin a settle wait
  input  wire logic       bypass_i,    // skip the lock wait
  input  wire logic       lock_i,      // synchronised lock indication
  input  wire logic [7:0] count_i,     // programmed lock count
  output logic            busy_o,      // wait in progress
  output logic            done_o       // one-cycle pulse at end of wait
);
  import rimc_pkg::*;

  localparam int UW = $clog2(UNIT_CYC);

  rimc_set_st_t    st_ff,   nxt_st;     // sequencer state
  logic [7:0]      units_ff, nxt_units; // units left
  logic [UW-1:0]   tick_ff, nxt_tick;   // cycles left in unit
  logic            done_ff, nxt_done;   // finish pulse

  // next state of the sequencer
  always_comb begin
    nxt_st    = st_ff;
    nxt_units = units_ff;
    nxt_tick  = tick_ff;
    nxt_done  = 1'b0;
    case (st_ff)
      RIMC_SET_IDLE: begin
        if (start_i) begin
          nxt_units = count_i;
          nxt_tick  = UW'(UNIT_CYC - 1);
          nxt_st    = bypass_i ? RIMC_SET_COUNT : RIMC_SET_LOCK;
        end
      end
      RIMC_SET_LOCK: begin
        if (lock_i) begin
          nxt_st = RIMC_SET_COUNT;
        end
      end
      RIMC_SET_COUNT: begin
        if (units_ff == 8'h00) begin
          nxt_done = 1'b1;
          nxt_st   = RIMC_SET_IDLE;
        end else if (tick_ff == '0) begin
          nxt_units = units_ff - 8'h01;
          nxt_tick  = UW'(UNIT_CYC - 1);
        end else begin
          nxt_tick = tick_ff - UW'(1);
        end
      end
      default: begin
        nxt_st = RIMC_SET_IDLE;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_ff    <= RIMC_SET_IDLE;
      units_ff <= 8'h00;
      tick_ff  <= '0;
      done_ff  <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      units_ff <= nxt_units;
      tick_ff  <= nxt_tick;
      done_ff  <= nxt_done;
    end
  end

  assign busy_o = (st_ff != RIMC_SET_IDLE);
  assign done_o = done_ff;
endmodule

// ---- core/rimc_top.sv ----
// rimc_top: identification and mode control registers behind the serial port
// assumes: host drives mode-0 serial frames, sck far slower than mclk_i
`timescale 1ns/100ps
`include "rimc_cfg.svh"
// What this block does
// - upper ident nibble shows silicon revision
// - lower ident nibble shows fixed product code
// - receive bit drives receive mode
// - transmit bit drives transmit mode
// - half select picks upper or lower 32
// - half select honoured only in 32-chip mode
// - no bypass: wait lock, then count
// - bypass: wait count only
// - settle count from 0x38, 2 us units
// - source bit picks baseband or firmware amplifier
// - firmware mode: amplifier follows enable bit
// - baseband mode ignores enable bit
// - code width 32 gates half select
// - registers reached over serial interface
module rimc_top #(
  parameter logic [3:0] SILICON_REV  = 4'h3,  // arbitrary value
  parameter logic [3:0] PRODUCT_CODE = 4'hA,  // arbitrary value
  parameter int         UNIT_CYC     = `RIMC_LOCK_UNIT_CYC
) (
  input  wire logic               mclk_i,            // device clock, 250 MHz
  input  wire logic               rst_b_i,           // sync reset, active low
  input  wire logic               spi_sck_i,         // serial clock pin
  input  wire logic               spi_cs_b_i,        // serial select pin, active low
  input  wire logic               spi_mosi_i,        // serial data in pin
  output logic                    spi_miso_o,        // serial data out
  output logic                    spi_miso_oe_o,     // miso driven while high
  input  wire logic               syn_lock_i,        // synthesizer lock, async
  input  wire logic               settle_start_i,    // request a settle wait
  input  wire logic               code_width_32_i,   // 32-chip codes selected
  input  wire logic [63:0]        pn_code_i,         // stored 64-chip code
  input  wire logic               baseband_pa_req_i, // baseband amplifier request
  output logic                    rx_enable_o,       // receive mode
  output logic                    tx_enable_o,       // transmit mode
  output logic [31:0]             pn_code_active_o,  // 32-chip code in use
  output logic                    code_upper_o,      // upper half in use
  output logic                    amp_on_o,          // internal amplifier enable
  output logic                    settle_busy_o,     // settle wait running
  output logic                    settle_done_o,     // settle wait finished, pulse
  output rimc_pkg::rimc_ctrl_t    ctrl_o             // decoded control fields
);
  import rimc_pkg::*;

  // pin synchronisers: stage one feeds only stage two
  logic [3:0] sync1_ff;   // first stage
  logic [3:0] sync2_ff;   // second stage, safe to read
  logic       sck_d_ff;   // previous synced sck for edges

  always_ff @(posedge mclk_i) begin
    sync1_ff <= {syn_lock_i, spi_mosi_i, spi_cs_b_i, spi_sck_i};
    sync2_ff <= sync1_ff;
    sck_d_ff <= sync2_ff[0];
  end

  logic sck_s, cs_b_s, mosi_s, lock_s;  // synced pins
  logic sck_rise, sck_fall;             // sck edges in mclk domain
  assign sck_s    = sync2_ff[0];
  assign cs_b_s   = sync2_ff[1];
  assign mosi_s   = sync2_ff[2];
  assign lock_s   = sync2_ff[3];
  assign sck_rise = sck_s & ~sck_d_ff;
  assign sck_fall = ~sck_s & sck_d_ff;

  // serial slave state
  rimc_spi_st_t            st_ff,    nxt_st;     // frame phase
  logic [2:0]              bit_ff,   nxt_bit;    // bit within byte
  logic [7:0]              shin_ff,  nxt_shin;   // receive shift
  logic [7:0]              shout_ff, nxt_shout;  // transmit shift
  logic                    wr_ff,    nxt_wr;     // frame is a write
  logic [`RIMC_ADDR_W-1:0] addr_ff,  nxt_addr;   // latched address
  logic                    wr_stb;               // commit one data byte
  logic [7:0]              wr_byte;              // full data byte at the last rise
  // the last data bit is still on mosi at the strobe, so the shift register lags a bit
  assign wr_byte = {shin_ff[6:0], mosi_s};

  // register bank
  logic [7:0] ctl_ff,  nxt_ctl;    // control register, bits 1:0 not stored
  logic [7:0] lock_ff, nxt_lock;   // settle count register
  logic [7:0] rd_data;             // read mux

  // read mux, pure decode with no side effects
  always_comb begin
    case (addr_ff)
      `RIMC_OFS_IDENT:    rd_data = {SILICON_REV, PRODUCT_CODE};
      `RIMC_OFS_CONTROL:  rd_data = ctl_ff;
      `RIMC_OFS_LOCK_CNT: rd_data = lock_ff;
      default:            rd_data = 8'h00;  // unmapped reads zero
    endcase
  end

  // serial frame: command byte, then one data byte
  always_comb begin
    nxt_st    = st_ff;
    nxt_bit   = bit_ff;
    nxt_shin  = shin_ff;
    nxt_shout = shout_ff;
    nxt_wr    = wr_ff;
    nxt_addr  = addr_ff;
    wr_stb    = 1'b0;
    if (cs_b_s) begin
      // deselect aborts any partial frame
      nxt_st  = RIMC_SPI_IDLE;
      nxt_bit = 3'h0;
    end else begin
      case (st_ff)
        RIMC_SPI_IDLE: begin
          nxt_st    = RIMC_SPI_ADDR;
          nxt_bit   = 3'h0;
          nxt_shout = 8'h00;
        end
        RIMC_SPI_ADDR: begin
          if (sck_rise) begin
            nxt_shin = {shin_ff[6:0], mosi_s};
            nxt_bit  = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_wr    = shin_ff[`RIMC_CMD_WR_BIT - 1];
              nxt_addr  = {shin_ff[`RIMC_ADDR_W-2:0], mosi_s};
              nxt_st    = RIMC_SPI_DATA;
            end
          end
        end
        RIMC_SPI_DATA: begin
          if (sck_rise) begin
            nxt_shin = {shin_ff[6:0], mosi_s};
            nxt_bit  = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              wr_stb = wr_ff;
              nxt_st = RIMC_SPI_DONE;
            end
          end else if (sck_fall && bit_ff != 3'h0) begin
            // shift only after a data rise; the fall ending the command keeps bit 7
            nxt_shout = {shout_ff[6:0], 1'h0};
          end else if (bit_ff == 3'h0) begin
            // load read data once the address has landed, before the first data rise
            nxt_shout = rd_data;
          end
        end
        RIMC_SPI_DONE: begin
          // extra clocks ignored until deselect
          nxt_shout = 8'h00;
        end
        default: begin
          nxt_st = RIMC_SPI_IDLE;
        end
      endcase
    end
  end

  // register writes
  always_comb begin
    nxt_ctl  = ctl_ff;
    nxt_lock = lock_ff;
    if (wr_stb) begin
      case (addr_ff)
        `RIMC_OFS_IDENT:    nxt_ctl  = ctl_ff;
        // reserved bits 1:0 always hold zero
        `RIMC_OFS_CONTROL:  nxt_ctl  = {wr_byte[7:2], 2'h0};
        `RIMC_OFS_LOCK_CNT: nxt_lock = wr_byte;
        default:            nxt_lock = lock_ff;
      endcase
    end
  end

  // register serial slave and bank
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_ff    <= RIMC_SPI_IDLE;
      bit_ff   <= 3'h0;
      shin_ff  <= 8'h00;
      shout_ff <= 8'h00;
      wr_ff    <= 1'b0;
      addr_ff  <= '0;
      ctl_ff   <= `RIMC_CONTROL_RST;
      lock_ff  <= `RIMC_LOCK_CNT_RST;
    end else begin
      st_ff    <= nxt_st;
      bit_ff   <= nxt_bit;
      shin_ff  <= nxt_shin;
      shout_ff <= nxt_shout;
      wr_ff    <= nxt_wr;
      addr_ff  <= nxt_addr;
      ctl_ff   <= nxt_ctl;
      lock_ff  <= nxt_lock;
    end
  end

  // miso driven only during a read data byte, msb first
  assign spi_miso_o    = shout_ff[7];
  assign spi_miso_oe_o = (st_ff == RIMC_SPI_DATA) & ~wr_ff & ~cs_b_s;

  // decoded control fields
  rimc_ctrl_t ctrl;
  assign ctrl.rx_en       = ctl_ff[`RIMC_CTL_RX_BIT];
  assign ctrl.tx_en       = ctl_ff[`RIMC_CTL_TX_BIT];
  assign ctrl.code_half   = ctl_ff[`RIMC_CTL_HALF_BIT];
  assign ctrl.lock_bypass = ctl_ff[`RIMC_CTL_BYPASS_BIT];
  assign ctrl.amp_src     = ctl_ff[`RIMC_CTL_SRC_BIT];
  assign ctrl.amp_en      = ctl_ff[`RIMC_CTL_AMP_BIT];
  assign ctrl_o           = ctrl;

  // mode outputs, registered
  logic        rx_ff,   nxt_rx;    // receive mode
  logic        tx_ff,   nxt_tx;    // transmit mode
  logic        upper_ff, nxt_upper; // upper code half
  logic [31:0] pn_ff,   nxt_pn;    // active code half
  logic        amp_ff,  nxt_amp;   // amplifier enable

  always_comb begin
    nxt_rx = ctrl.rx_en;
    nxt_tx = ctrl.tx_en;
    nxt_upper = code_width_32_i & ctrl.code_half;
    nxt_pn = nxt_upper ? pn_code_i[63:32] : pn_code_i[31:0];
    nxt_amp = ctrl.amp_src ? ctrl.amp_en : baseband_pa_req_i;
  end

  // register mode outputs
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rx_ff    <= 1'b0;
      tx_ff    <= 1'b0;
      upper_ff <= 1'b0;
      pn_ff    <= 32'h0000_0000;
      amp_ff   <= 1'b0;
    end else begin
      rx_ff    <= nxt_rx;
      tx_ff    <= nxt_tx;
      upper_ff <= nxt_upper;
      pn_ff    <= nxt_pn;
      amp_ff   <= nxt_amp;
    end
  end

  assign rx_enable_o      = rx_ff;
  assign tx_enable_o      = tx_ff;
  assign code_upper_o     = upper_ff;
  assign pn_code_active_o = pn_ff;
  assign amp_on_o         = amp_ff;

  rimc_settle #(
    .UNIT_CYC (UNIT_CYC)
  ) u_settle (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .start_i  (settle_start_i),
    .bypass_i (ctrl.lock_bypass),
    .lock_i   (lock_s),
    .count_i  (lock_ff),
    .busy_o   (settle_busy_o),
    .done_o   (settle_done_o)
  );
endmodule

// ---- verif/rimc_top_sva.sv ----
// rimc_top_sva: port checks for the mode control block
// assumes: bound into rimc_top, one clock, sync active-low reset
`timescale 1ns/100ps
module rimc_top_sva
  import rimc_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        spi_cs_b_i,
  input wire logic        spi_miso_oe_o,
  input wire logic        syn_lock_i,
  input wire logic        settle_start_i,
  input wire logic        code_width_32_i,
  input wire logic [63:0] pn_code_i,
  input wire logic        baseband_pa_req_i,
  input wire logic        rx_enable_o,
  input wire logic        tx_enable_o,
  input wire logic [31:0] pn_code_active_o,
  input wire logic        code_upper_o,
  input wire logic        amp_on_o,
  input wire logic        settle_busy_o,
  input wire logic        settle_done_o,
  input wire rimc_ctrl_t  ctrl_o
);
  logic [63:0] pn_ff;   // stored code one cycle back
  logic        up_ff;   // expected half select
  logic        amp_ff;  // expected amplifier state
  // reference copies lag one cycle, as the registered outputs do
  always_ff @(posedge mclk_i) begin
    pn_ff  <= pn_code_i;
    up_ff  <= code_width_32_i & ctrl_o.code_half;
    amp_ff <= ctrl_o.amp_src ? ctrl_o.amp_en : baseband_pa_req_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  chk_rx_mode: assert property ($past(rst_b_i) |-> rx_enable_o == $past(ctrl_o.rx_en))
    else $error("receive mode not following control");
  chk_tx_mode: assert property ($past(rst_b_i) |-> tx_enable_o == $past(ctrl_o.tx_en))
    else $error("transmit mode not following control");
  chk_half_gate: assert property ($past(rst_b_i) |-> code_upper_o == up_ff)
    else $error("half select not gated by code width");
  chk_code_half: assert property ($past(rst_b_i) |-> pn_code_active_o == (up_ff ? pn_ff[63:32] : pn_ff[31:0]))
    else $error("wrong code half in use");
  chk_amp_src: assert property ($past(rst_b_i) |-> amp_on_o == amp_ff)
    else $error("amplifier not following its source");
  chk_oe_idle: assert property (spi_cs_b_i [*4] |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  chk_done_pulse: assert property (settle_done_o |=> !settle_done_o)
    else $error("settle done longer than one cycle");
  chk_done_idle: assert property (settle_done_o |-> !settle_busy_o)
    else $error("busy still high at done");
  chk_start_busy: assert property (settle_start_i && !settle_busy_o |=> settle_busy_o)
    else $error("settle start not taken");
  chk_lock_first: assert property (settle_done_o && !ctrl_o.lock_bypass |-> $past(syn_lock_i, 4))
    else $error("settle done without lock");
  cov_rx_write: cover property ($rose(rx_enable_o));
  cov_lock_done: cover property (settle_done_o && !ctrl_o.lock_bypass);
  cov_read_out: cover property ($rose(spi_miso_oe_o));
endmodule

bind rimc_top rimc_top_sva rimc_top_sva_i (.mclk_i, .rst_b_i, .spi_cs_b_i, .spi_miso_oe_o, .syn_lock_i,
  .settle_start_i, .code_width_32_i, .pn_code_i, .baseband_pa_req_i, .rx_enable_o, .tx_enable_o,
  .pn_code_active_o, .code_upper_o, .amp_on_o, .settle_busy_o, .settle_done_o, .ctrl_o);

// ---- verif/rimc_host.sv ----
// rimc_host: host controller model, mode-0 serial frames
// assumes: bench calls xfer; sck stands low between frames
`timescale 1ns/100ps
module rimc_host (
  input  wire logic mclk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  output logic      sck_o,
  output logic      cs_b_o,
  output logic      mosi_o
);
  // idle pins: deselected, clock low
  initial begin
    sck_o  = 1'h0;
    cs_b_o = 1'h1;
    mosi_o = 1'h0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int half, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    if (cmd[5:0] == 6'h03)
      sh[1:0] = 2'h0;
    @(negedge mclk_i) cs_b_o = 1'h0;
    repeat (4) @(negedge mclk_i);
    for (int i = 0; i < 16; i++) begin
      mosi_o = sh[15 - i];
      repeat (half) @(negedge mclk_i);
      // undriven miso reads as a changing pattern, never a stale bit
      rd = {rd[6:0], miso_oe_i ? miso_i : ~rd[0]};
      sck_o = 1'h1;
      repeat (half) @(negedge mclk_i);
      sck_o = 1'h0;
    end
    repeat (half) @(negedge mclk_i);
    cs_b_o = 1'h1;
    mosi_o = ~mosi_o;
    repeat (6) @(negedge mclk_i);
  endtask
endmodule

// ---- verif/test_radio_ident_and_mode_control.sv ----
// test_radio_ident_and_mode_control: self-checking bench for rimc_top
// assumes: rimc_host drives the serial pins; checker bound separately
`timescale 1ns/100ps
`include "rimc_cfg.svh"
module test_radio_ident_and_mode_control;
  import rimc_pkg::*;
  localparam int         U    = 4;     // short count unit keeps runs brief
  localparam logic [3:0] SREV = 4'h2;  // arbitrary value
  localparam logic [3:0] PROD = 4'h9;  // arbitrary value
  localparam logic [7:0] MODES [4] = '{8'h80, 8'h40, 8'hC0, 8'h00};
  logic        mclk_i, rst_b_i, sck, cs_b, mosi, miso, miso_oe;
  logic        lock, start, cw32, bb_req, rx_en, tx_en, upper, amp_on, busy, done;
  logic [63:0] pn;          // stored code
  logic [31:0] pn_act;      // code in use
  rimc_ctrl_t  ctrl;        // decoded fields
  logic [7:0]  r;           // last read byte
  int          hp = 8;      // host half period, 8 is the fastest legal
  int          n_mismatch = 0;
  int          compares = 0;
  rimc_top #(.SILICON_REV(SREV), .PRODUCT_CODE(PROD), .UNIT_CYC(U)) rimc_top_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .spi_sck_i(sck), .spi_cs_b_i(cs_b), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .syn_lock_i(lock), .settle_start_i(start),
    .code_width_32_i(cw32), .pn_code_i(pn), .baseband_pa_req_i(bb_req), .rx_enable_o(rx_en),
    .tx_enable_o(tx_en), .pn_code_active_o(pn_act), .code_upper_o(upper), .amp_on_o(amp_on),
    .settle_busy_o(busy), .settle_done_o(done), .ctrl_o(ctrl));
  rimc_host rimc_host_i (.mclk_i(mclk_i), .miso_i(miso), .miso_oe_i(miso_oe), .sck_o(sck),
    .cs_b_o(cs_b), .mosi_o(mosi));
  // 250 MHz device clock
  initial begin
    mclk_i = 1'h0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // one frame: write flag, address, data
  task automatic xf(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    rimc_host_i.xfer({w, 1'h0, a}, d, hp, q);
  endtask
  // bounded wait for the settle pulse; running out ends the run
  task automatic wait_done(input int max, output int n);
    n = 0;
    while (done !== 1'h1 && n < max) begin
      tick(1);
      n++;
    end
    if (n >= max) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic t_reset_vals();
    check(ctrl, '0);
    check({rx_en, tx_en, amp_on, busy, done}, 5'h00);
    xf(1'h0, `RIMC_OFS_IDENT, 8'h00, r);
    check(r[7:4], SREV);
    check(r[3:0], PROD);
    xf(1'h0, `RIMC_OFS_CONTROL, 8'h00, r);
    check(r, 8'h00);
    xf(1'h0, `RIMC_OFS_LOCK_CNT, 8'h00, r);
    check(r, 8'h64);
    xf(1'h0, 6'h2A, 8'h00, r);
    check(r, 8'h00);
  endtask
  task automatic t_ident_ro();
    xf(1'h1, `RIMC_OFS_IDENT, 8'hFF, r);
    xf(1'h0, `RIMC_OFS_IDENT, 8'h00, r);
    check(r, {SREV, PROD});
    check(ctrl, '0);
  endtask
  // slow host here, fastest elsewhere
  task automatic t_modes();
    hp = 12;
    foreach (MODES[i]) begin
      xf(1'h1, `RIMC_OFS_CONTROL, MODES[i], r);
      tick(1);
      check(rx_en, MODES[i][7]);
      check(tx_en, MODES[i][6]);
      xf(1'h0, `RIMC_OFS_CONTROL, 8'h00, r);
      check(r, MODES[i]);
    end
    hp = 8;
  endtask
  task automatic t_code();
    for (int w = 0; w < 2; w++) begin
      for (int h = 0; h < 2; h++) begin
        xf(1'h1, `RIMC_OFS_CONTROL, {2'h0, h[0], 5'h00}, r);
        cw32 = w[0];
        tick(2);
        check(upper, w[0] & h[0]);
        check(pn_act, (w[0] & h[0]) ? pn[63:32] : pn[31:0]);
      end
    end
  endtask
  task automatic amp_case(input logic [7:0] c, input logic q, input logic e);
    xf(1'h1, `RIMC_OFS_CONTROL, c, r);
    bb_req = q;
    tick(2);
    check(amp_on, e);
  endtask
  task automatic t_amp();
    amp_case(8'h04, 1'h0, 1'h0);
    amp_case(8'h00, 1'h1, 1'h1);
    amp_case(8'h08, 1'h1, 1'h0);
    amp_case(8'h0C, 1'h0, 1'h1);
  endtask
  task automatic t_settle_bypass();
    int n;
    xf(1'h1, `RIMC_OFS_LOCK_CNT, 8'h03, r);
    xf(1'h1, `RIMC_OFS_CONTROL, 8'h10, r);
    start = 1'h1;
    tick(1);
    start = 1'h0;
    wait_done(100, n);
    check(n >= 3 * U && n <= 3 * (U + 1) + 4, 1'h1);
  endtask
  task automatic t_settle_lock();
    int n;
    xf(1'h1, `RIMC_OFS_LOCK_CNT, 8'h19, r);
    xf(1'h1, `RIMC_OFS_CONTROL, 8'h00, r);
    start = 1'h1;
    tick(1);
    start = 1'h0;
    n = 0;
    repeat (150) begin
      tick(1);
      n += done;
    end
    check(n, 0);
    lock = 1'h1;
    wait_done(400, n);
    check(n >= 25 * U && n <= 25 * (U + 1) + 8, 1'h1);
    lock = 1'h0;
  endtask
  // main sequence
  initial begin
    rst_b_i = 1'h0;
    lock = 1'h0;
    start = 1'h0;
    cw32 = 1'h0;
    bb_req = 1'h0;
    pn = 64'h0123_4567_89AB_CDEF;
    tick(3);
    rst_b_i = 1'h1;
    tick(8);
    t_reset_vals();
    t_ident_ro();
    t_modes();
    t_code();
    t_amp();
    t_settle_bypass();
    t_settle_lock();
    end_of_test();
  end
endmodule
